// ==== rtl/arcz_zone_trip.sv ====
/*
 Arc zone decision logic: settings and status registers, blocking sample,
 current conditions and four zone trip/blocked flags.
 Assumes sensor, block and sample inputs synchronous to sys_clk, and a
 register master that never issues read and write strobes together.
*/
`timescale 1ns/1ps
module arcz_zone_trip #(
   parameter int CYCLE_CLKS = arcz_pkg::CYCLE_CLKS,
   parameter int ZONES = arcz_pkg::ZONES,
   parameter int CHANS = arcz_pkg::CHANS
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [CHANS-1:0] light,
   input wire logic [CHANS-1:0] pressure,
   input wire logic option_card_input,
   input wire logic block_in,
   input wire logic [CHANS-1:0] sensor_fault,
   input wire logic io_fault,
   input wire logic sample_valid,
   input wire logic [arcz_pkg::PU_W-1:0] phase_a,
   input wire logic [arcz_pkg::PU_W-1:0] phase_b,
   input wire logic [arcz_pkg::PU_W-1:0] phase_c,
   input wire logic [arcz_pkg::PU_W-1:0] residual_channel_one,
   input wire logic [arcz_pkg::PU_W-1:0] residual_channel_two,
   output logic [ZONES-1:0] zone_trip,
   output logic [ZONES-1:0] zone_blocked
);
   // The register map packs four zones and four channels
   if (ZONES != 4 || CHANS != 4) begin : g_chk
      $error("register map serves four zones and four channels");
   end

   localparam int PW = arcz_pkg::PU_W;
   localparam int ZW = arcz_pkg::ZC_W;

   // Settings
   logic [2:0] mode; // Behaviour mode
   logic [PW-1:0] ph_pu; // Phase pick-up
   logic [PW-1:0] res_pu; // Residual pick-up
   logic [1:0] res_sel; // Residual source
   logic [7:0] samp_req; // Required sample count
   logic [ZW-1:0] zcfg [ZONES]; // Zone configuration words
   logic [2:0] next_mode;
   logic [PW-1:0] next_ph_pu;
   logic [PW-1:0] next_res_pu;
   logic [1:0] next_res_sel;
   logic [7:0] next_samp_req;
   logic [ZW-1:0] next_zcfg [ZONES];
   logic [31:0] next_rdata;

   // Processing state
   arcz_pkg::arcz_phase_t phase; // Wait or evaluate
   arcz_pkg::arcz_phase_t next_phase;
   logic blk_s; // Sampled block input
   logic next_blk_s;
   logic [ZONES-1:0] trip_f; // Zone trip flags
   logic [ZONES-1:0] blk_f; // Zone blocked flags
   logic [ZONES-1:0] next_trip_f;
   logic [ZONES-1:0] next_blk_f;

   // Combinational helpers
   logic cycle_start; // Processing cycle begins
   logic eval; // Evaluation cycle
   logic blk_eff; // Block input or blocked mode
   logic func_off; // Mode off
   logic test_mode; // Trip outputs held back
   logic ph_over; // Any phase above pick-up
   logic res_over; // Selected residual above pick-up
   logic ph_cond; // Phase condition active
   logic res_cond; // Residual condition active
   logic [ZONES-1:0] pick; // Zone pick-up

   // True when a threshold write is inside the setting range
   function automatic logic pu_ok(input logic [31:0] v);
      return (v[PW-1:0] >= arcz_pkg::PU_MIN) && (v[PW-1:0] <= arcz_pkg::PU_MAX) && (v[31:PW] == '0);
   endfunction

   // Zone pick-up from its configuration and the live sources
   function automatic logic zone_pick(input logic [ZW-1:0] c, input logic [3:0] li, input logic [3:0] pr,
                                      input logic oci, input logic phc, input logic rsc);
      logic cur_en;
      logic cur_ok;
      logic lt;
      logic pt;
      logic sens;
      logic [1:0] dm;
      cur_en = c[arcz_pkg::ZC_PH] | c[arcz_pkg::ZC_RES];
      cur_ok = (c[arcz_pkg::ZC_PH] & phc) | (c[arcz_pkg::ZC_RES] & rsc);
      lt = |(li & c[arcz_pkg::ZC_LIGHT_LSB +: 4]);
      pt = |(pr & c[arcz_pkg::ZC_PRES_LSB +: 4]);
      if (cur_en) begin
         lt = lt & cur_ok;
      end
      sens = lt | pt;
      dm = c[arcz_pkg::ZC_OCI_LSB +: 2];
      if (dm == arcz_pkg::OCI_QUAL) begin
         sens = sens & oci;
      end else if (dm == arcz_pkg::OCI_DIRECT) begin
         sens = sens | oci;
      end
      return c[arcz_pkg::ZC_EN] & sens;
   endfunction

   // Processing cycle divider
   arcz_cycle_timer #(
      .CYCLE_CLKS(CYCLE_CLKS)
   ) u_timer (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .cycle_start(cycle_start)
   );

   // Sample comparisons against the pick-up thresholds
   always_comb begin
      ph_over = (phase_a > ph_pu) || (phase_b > ph_pu) || (phase_c > ph_pu);
      case (res_sel)
         arcz_pkg::RSEL_ONE: res_over = residual_channel_one > res_pu;
         arcz_pkg::RSEL_TWO: res_over = residual_channel_two > res_pu;
         default: res_over = 1'b0;
      endcase
   end

   // Phase current condition over the time base
   arcz_curr_cond #(
      .CNT_W(8)
   ) u_ph_cond (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .window_end(cycle_start),
      .sample_valid(sample_valid),
      .sample_over(ph_over),
      .req_count(samp_req),
      .cond(ph_cond)
   );

   // Residual current condition over the time base
   arcz_curr_cond #(
      .CNT_W(8)
   ) u_res_cond (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .window_end(cycle_start),
      .sample_valid(sample_valid),
      .sample_over(res_over),
      .req_count(samp_req),
      .cond(res_cond)
   );

   // Mode decode
   assign eval = (phase == arcz_pkg::PH_EVAL);
   assign func_off = (mode == arcz_pkg::BEH_OFF);
   assign test_mode = (mode == arcz_pkg::BEH_TEST) || (mode == arcz_pkg::BEH_TEST_BLOCKED);
   assign blk_eff = blk_s || (mode == arcz_pkg::BEH_BLOCKED) || (mode == arcz_pkg::BEH_TEST_BLOCKED);

   // Per-zone pick-up
   for (genvar z = 0; z < ZONES; z++) begin : g_zone
      assign pick[z] = zone_pick(zcfg[z], light, pressure, option_card_input, ph_cond, res_cond);
   end

   // Register writes and read data; settings change while running
   always_comb begin
      next_mode = mode;
      next_ph_pu = ph_pu;
      next_res_pu = res_pu;
      next_res_sel = res_sel;
      next_samp_req = samp_req;
      next_zcfg = zcfg;
      next_rdata = 32'h0000_0000;
      if (wr) begin
         case (addr)
            arcz_pkg::OFF_CTRL: begin
               if (wdata[2:0] <= 3'(arcz_pkg::BEH_OFF)) begin
                  next_mode = wdata[2:0];
               end
            end
            arcz_pkg::OFF_PH_PU: begin
               if (pu_ok(wdata)) begin
                  next_ph_pu = wdata[PW-1:0];
               end
            end
            arcz_pkg::OFF_RES_PU: begin
               if (pu_ok({20'h00000, wdata[PW-1:0]})) begin
                  next_res_pu = wdata[PW-1:0];
               end
               if (wdata[arcz_pkg::RES_SEL_LSB +: 2] <= 2'(arcz_pkg::RSEL_TWO)) begin
                  next_res_sel = wdata[arcz_pkg::RES_SEL_LSB +: 2];
               end
            end
            arcz_pkg::OFF_SAMP_REQ: begin
               if (wdata[7:0] != 8'h00) begin
                  next_samp_req = wdata[7:0];
               end
            end
            default: begin
               for (int z = 0; z < ZONES; z++) begin
                  if (addr == arcz_pkg::OFF_ZONE0 + 8'(4 * z)) begin
                     next_zcfg[z] = wdata[ZW-1:0];
                  end
               end
            end
         endcase
      end
      if (rd) begin
         case (addr)
            arcz_pkg::OFF_CTRL: next_rdata[2:0] = mode;
            arcz_pkg::OFF_PH_PU: next_rdata[PW-1:0] = ph_pu;
            arcz_pkg::OFF_RES_PU: next_rdata = {18'h00000, res_sel, res_pu};
            arcz_pkg::OFF_SAMP_REQ: next_rdata[7:0] = samp_req;
            arcz_pkg::OFF_COND: begin
               next_rdata[arcz_pkg::CS_TRIP_LSB +: 4] = trip_f;
               next_rdata[arcz_pkg::CS_BLK_LSB +: 4] = blk_f;
            end
            arcz_pkg::OFF_SENS: begin
               next_rdata[arcz_pkg::SS_PH_BLK] = ph_cond & blk_eff;
               next_rdata[arcz_pkg::SS_PH_START] = ph_cond & ~blk_eff;
               next_rdata[arcz_pkg::SS_RES_BLK] = res_cond & blk_eff;
               next_rdata[arcz_pkg::SS_RES_START] = res_cond & ~blk_eff;
               next_rdata[arcz_pkg::SS_LIGHT_LSB +: 4] = light;
               next_rdata[arcz_pkg::SS_PRES_LSB +: 4] = pressure;
               next_rdata[arcz_pkg::SS_OCI] = option_card_input;
               next_rdata[arcz_pkg::SS_FAULT_LSB +: 4] = sensor_fault;
               next_rdata[arcz_pkg::SS_IO_FAULT] = io_fault;
            end
            arcz_pkg::OFF_BEHAV: next_rdata[2:0] = mode;
            default: begin
               for (int z = 0; z < ZONES; z++) begin
                  if (addr == arcz_pkg::OFF_ZONE0 + 8'(4 * z)) begin
                     next_rdata[ZW-1:0] = zcfg[z];
                  end
               end
            end
         endcase
      end
   end

   // Register settings and read data
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         mode <= 3'(arcz_pkg::BEH_ON);
         ph_pu <= arcz_pkg::PU_DEFAULT;
         res_pu <= arcz_pkg::PU_DEFAULT;
         res_sel <= 2'(arcz_pkg::RSEL_NONE);
         samp_req <= arcz_pkg::SAMP_REQ_DEFAULT;
         for (int z = 0; z < ZONES; z++) begin
            zcfg[z] <= arcz_pkg::ZONE_CFG_RST;
         end
         rdata <= 32'h0000_0000;
      end else begin
         mode <= next_mode;
         ph_pu <= next_ph_pu;
         res_pu <= next_res_pu;
         res_sel <= next_res_sel;
         samp_req <= next_samp_req;
         zcfg <= next_zcfg;
         rdata <= next_rdata;
      end
   end

   // Sample block at cycle start, decide flags in the next cycle
   always_comb begin
      next_phase = phase;
      next_blk_s = blk_s;
      next_trip_f = trip_f;
      next_blk_f = blk_f;
      case (phase)
         arcz_pkg::PH_WAIT: begin
            if (cycle_start) begin
               next_blk_s = block_in;
               next_phase = arcz_pkg::PH_EVAL;
            end
         end
         arcz_pkg::PH_EVAL: begin
            if (func_off) begin
               next_trip_f = '0;
               next_blk_f = '0;
            end else begin
               next_trip_f = pick & {ZONES{~blk_eff}};
               next_blk_f = pick & {ZONES{blk_eff}};
            end
            next_phase = arcz_pkg::PH_WAIT;
         end
         default: next_phase = arcz_pkg::PH_WAIT;
      endcase
   end

   // Register processing state and flags
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         phase <= arcz_pkg::PH_WAIT;
         blk_s <= 1'b0;
         trip_f <= '0;
         blk_f <= '0;
      end else begin
         phase <= next_phase;
         blk_s <= next_blk_s;
         trip_f <= next_trip_f;
         blk_f <= next_blk_f;
      end
   end

   // Test modes keep the trip outputs quiet
   assign zone_trip = trip_f & {ZONES{~test_mode}};
   assign zone_blocked = blk_f;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_start;
      cycle_start ##1 eval;
   endsequence
   property p_eval_once;
      s_start |=> !eval;
   endproperty
   a_eval_once: assert property (p_eval_once) else $error("evaluation not one cycle");

   property p_block_held;
      !cycle_start |=> $stable(blk_s);
   endproperty
   a_block_held: assert property (p_block_held) else $error("block sample moved mid cycle");

   property p_trip;
      eval && pick[0] && !blk_eff && !func_off |=> trip_f[0] && !blk_f[0];
   endproperty
   a_trip: assert property (p_trip) else $error("zone trip missing");

   property p_blocked;
      eval && pick[0] && blk_eff && !func_off |=> blk_f[0] && !trip_f[0];
   endproperty
   a_blocked: assert property (p_blocked) else $error("blocked indication missing");

   property p_disabled;
      eval && !zcfg[0][arcz_pkg::ZC_EN] |=> !trip_f[0] && !blk_f[0];
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled zone acted");

   property p_hold;
      !eval |=> $stable(trip_f) && $stable(blk_f);
   endproperty
   a_hold: assert property (p_hold) else $error("flags moved outside evaluation");

   property p_cond_read;
      rd && addr == arcz_pkg::OFF_COND |=> rdata[7:0] == {$past(blk_f), $past(trip_f)};
   endproperty
   a_cond_read: assert property (p_cond_read) else $error("condition status wrong");

   property p_direct;
      eval && zcfg[0] == ZW'(13'h0801) && option_card_input && !blk_eff && !func_off |=> trip_f[0];
   endproperty
   a_direct: assert property (p_direct) else $error("direct input did not trip");

   property p_qual;
      eval && zcfg[0][arcz_pkg::ZC_OCI_LSB +: 2] == 2'(arcz_pkg::OCI_QUAL) && !option_card_input |=> !trip_f[0];
   endproperty
   a_qual: assert property (p_qual) else $error("qualifying mode tripped without input");

   property p_off;
      eval && func_off |=> trip_f == '0 && blk_f == '0;
   endproperty
   a_off: assert property (p_off) else $error("off mode produced flags");

   property p_light_needs_current;
      eval && zcfg[0] == ZW'(13'h000B) && !ph_cond |=> !trip_f[0];
   endproperty
   a_light_needs_current: assert property (p_light_needs_current) else $error("light tripped without current");
endmodule

// ==== shared/arcz_pkg.sv ====
/*
 Constants, field layouts and types shared by the arc zone decision logic.
 Assumes a single 40 MHz system clock and per-unit magnitudes in 0.01 steps.
*/
package arcz_pkg;
   // Zone and sensor channel counts
   localparam int ZONES = 4;
   localparam int CHANS = 4;
   // Register word offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PH_PU = 8'h04;
   localparam logic [7:0] OFF_RES_PU = 8'h08;
   localparam logic [7:0] OFF_SAMP_REQ = 8'h0C;
   localparam logic [7:0] OFF_ZONE0 = 8'h10;
   localparam logic [7:0] OFF_COND = 8'h20;
   localparam logic [7:0] OFF_SENS = 8'h24;
   localparam logic [7:0] OFF_BEHAV = 8'h28;
   // Zone configuration word fields
   localparam int ZC_EN = 0;
   localparam int ZC_PH = 1;
   localparam int ZC_RES = 2;
   localparam int ZC_LIGHT_LSB = 3;
   localparam int ZC_PRES_LSB = 7;
   localparam int ZC_OCI_LSB = 11;
   localparam int ZC_W = 13;
   localparam logic [ZC_W-1:0] ZONE_CFG_RST = 13'h0000;
   // Pick-up thresholds, units of 0.01 x nominal
   localparam int PU_W = 12;
   localparam logic [PU_W-1:0] PU_DEFAULT = 12'h078;
   localparam logic [PU_W-1:0] PU_MIN = 12'h005;
   localparam logic [PU_W-1:0] PU_MAX = 12'hFA0;
   localparam int RES_SEL_LSB = 12;
   // Required over-threshold samples per time base
   localparam logic [7:0] SAMP_REQ_DEFAULT = 8'h04;
   // Condition status fields
   localparam int CS_TRIP_LSB = 0;
   localparam int CS_BLK_LSB = 4;
   // Sensor status fields
   localparam int SS_PH_BLK = 0;
   localparam int SS_PH_START = 1;
   localparam int SS_RES_BLK = 2;
   localparam int SS_RES_START = 3;
   localparam int SS_LIGHT_LSB = 4;
   localparam int SS_PRES_LSB = 8;
   localparam int SS_OCI = 12;
   localparam int SS_FAULT_LSB = 13;
   localparam int SS_IO_FAULT = 17;
   // Processing cycle, equal to the 5 ms sample time base
   localparam int CYCLE_TIME_US = 5000;
   localparam int CLK_MHZ = 40;
   localparam int CYCLE_CLKS = CYCLE_TIME_US * CLK_MHZ;
   // Residual source selector
   typedef enum logic [1:0] {RSEL_NONE, RSEL_ONE, RSEL_TWO} arcz_rsel_t;
   // Digital input mode per zone
   typedef enum logic [1:0] {OCI_OFF, OCI_DIRECT, OCI_QUAL} arcz_oci_t;
   // Function behaviour modes
   typedef enum logic [2:0] {BEH_ON, BEH_BLOCKED, BEH_TEST, BEH_TEST_BLOCKED, BEH_OFF} arcz_beh_t;
   // Processing phase
   typedef enum logic {PH_WAIT, PH_EVAL} arcz_phase_t;
endpackage

// ==== rtl/arcz_cycle_timer.sv ====
/*
 Divider that marks the start of each processing cycle with a one-cycle pulse.
 Assumes sys_clk and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module arcz_cycle_timer #(
   parameter int CYCLE_CLKS = arcz_pkg::CYCLE_CLKS
) (
   input wire logic sys_clk,
   input wire logic nrst,
   output logic cycle_start
);
   localparam int CW = $clog2(CYCLE_CLKS);
   localparam logic [CW-1:0] LAST = CW'(CYCLE_CLKS - 1);

   // Refuse periods the counter cannot serve
   if (CYCLE_CLKS < 2) begin : g_chk
      $error("cycle length too short");
   end

   logic [CW-1:0] cnt; // Cycles into current period
   logic [CW-1:0] next_cnt;

   // Wrap the counter at the period end
   always_comb begin
      next_cnt = (cnt == LAST) ? '0 : cnt + 1'b1;
   end

   // Register counter
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Pulse on the last count of every period
   assign cycle_start = (cnt == LAST);
endmodule

// ==== rtl/arcz_curr_cond.sv ====
/*
 Counts over-threshold current samples inside one time base and, at its end,
 raises the condition if the required number was reached. Assumes one sample per strobe.
*/
`timescale 1ns/1ps
module arcz_curr_cond #(
   parameter int CNT_W = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic window_end,
   input wire logic sample_valid,
   input wire logic sample_over,
   input wire logic [CNT_W-1:0] req_count,
   output logic cond
);
   if (CNT_W < 1) begin : g_chk
      $error("count width too small");
   end

   logic [CNT_W-1:0] cnt; // Over-threshold samples so far
   logic [CNT_W-1:0] next_cnt;
   logic next_cond;
   logic hit; // This sample counts

   // Saturating count; result taken at window end
   always_comb begin
      hit = sample_valid && sample_over && (cnt != '1);
      next_cnt = hit ? cnt + 1'b1 : cnt;
      next_cond = cond;
      if (window_end) begin
         next_cond = (next_cnt >= req_count);
         next_cnt = '0;
      end
   end

   // Register count and condition
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt <= '0;
         cond <= 1'b0;
      end else begin
         cnt <= next_cnt;
         cond <= next_cond;
      end
   end
endmodule

// ==== tb/arcz_zone_trip_tb.sv ====
/*
 Self-checking bench for the arc zone decision logic: zone term table,
 blocking, current conditions, modes, settings and status words.
 Assumes the design's register map and a shortened processing cycle.
*/
`timescale 1ns/1ps
module arcz_zone_trip_tb;
   localparam int CYC = 20; // Short processing cycle for simulation
   // Table row: zone 0 config, sensor inputs, expected trip flags
   typedef struct packed {
      logic [31:0] cfg;
      logic [3:0] lt;
      logic [3:0] pr;
      logic oci;
      logic [3:0] trip;
   } arcz_row_t;
   logic sys_clk = 1'b0; // System clock
   logic nrst = 1'b0; // Reset, active low
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [3:0] light = 4'h0;
   logic [3:0] pressure = 4'h0;
   logic [3:0] sensor_fault = 4'h0;
   logic option_card_input = 1'b0;
   logic block_in = 1'b0;
   logic io_fault = 1'b0;
   logic sample_valid = 1'b0;
   logic [11:0] ph = 12'h000; // Phase A magnitude
   logic [11:0] phb = 12'h000; // Phase B magnitude
   logic [11:0] phc = 12'h000; // Phase C magnitude
   logic [11:0] r1 = 12'h000; // Residual one magnitude
   logic [11:0] r2 = 12'h000; // Residual two magnitude
   logic [3:0] zone_trip;
   logic [3:0] zone_blocked;
   int fails = 0;
   int cmp_count = 0;
   arcz_row_t rows [9];
   // Clock at 40 MHz
   always #12.5 sys_clk = ~sys_clk;
   arcz_zone_trip #(.CYCLE_CLKS(CYC)) DUT (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .light(light), .pressure(pressure),
      .option_card_input(option_card_input), .block_in(block_in), .sensor_fault(sensor_fault),
      .io_fault(io_fault), .sample_valid(sample_valid), .phase_a(ph), .phase_b(phb),
      .phase_c(phc), .residual_channel_one(r1), .residual_channel_two(r2),
      .zone_trip(zone_trip), .zone_blocked(zone_blocked));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle register write
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   // One-cycle read, data taken in the following cycle
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Read and compare
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask
   // Let two full processing cycles pass
   task automatic settle();
      repeat (2 * CYC + 3) @(posedge sys_clk);
      #1;
   endtask
   // Verdict
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      logic [31:0] d;
      rows[0] = '{32'h0000_1FFE, 4'hF, 4'hF, 1'b1, 4'h0};
      rows[1] = '{32'h0000_0009, 4'h1, 4'h0, 1'b0, 4'h1};
      rows[2] = '{32'h0000_0021, 4'h1, 4'h0, 1'b0, 4'h0};
      rows[3] = '{32'h0000_0401, 4'h0, 4'h8, 1'b0, 4'h1};
      rows[4] = '{32'h0000_0801, 4'h0, 4'h0, 1'b1, 4'h1};
      rows[5] = '{32'h0000_1009, 4'h0, 4'h0, 1'b1, 4'h0};
      rows[6] = '{32'h0000_1009, 4'h1, 4'h0, 1'b1, 4'h1};
      rows[7] = '{32'h0000_000B, 4'h1, 4'h0, 1'b0, 4'h0};
      rows[8] = '{32'h0000_0083, 4'h0, 4'h1, 1'b0, 4'h1};
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      #1;
      chk({28'h0, zone_trip}, 32'h0000_0000);
      rd_chk(arcz_pkg::OFF_CTRL, 32'h0000_0000);
      rd_chk(arcz_pkg::OFF_PH_PU, 32'h0000_0078);
      rd_chk(arcz_pkg::OFF_RES_PU, 32'h0000_0078);
      rd_chk(arcz_pkg::OFF_ZONE0, 32'h0000_0000);
      rd_chk(8'h30, 32'h0000_0000);
      $display("test reset done");
      // Table walk, settings changed live without reset
      foreach (rows[i]) begin
         wr_reg(arcz_pkg::OFF_ZONE0, rows[i].cfg);
         light <= rows[i].lt;
         pressure <= rows[i].pr;
         option_card_input <= rows[i].oci;
         settle();
         chk({28'h0, zone_trip}, {28'h0, rows[i].trip});
         rd_chk(arcz_pkg::OFF_COND, {28'h0, rows[i].trip});
      end
      $display("test table done");
      // Blocking input turns trip into blocked
      wr_reg(arcz_pkg::OFF_ZONE0, 32'h0000_0009);
      light <= 4'h1;
      option_card_input <= 1'b0;
      pressure <= 4'h0;
      block_in <= 1'b1;
      settle();
      chk({24'h0, zone_blocked, zone_trip}, 32'h0000_0010);
      rd_chk(arcz_pkg::OFF_COND, 32'h0000_0010);
      @(posedge sys_clk);
      block_in <= 1'b0;
      settle();
      chk({24'h0, zone_blocked, zone_trip}, 32'h0000_0001);
      $display("test block done");
      // Phase current gating at the threshold and just above it
      wr_reg(arcz_pkg::OFF_ZONE0, 32'h0000_000B);
      sample_valid <= 1'b1;
      ph <= 12'h078;
      settle();
      chk({28'h0, zone_trip}, 32'h0000_0000);
      // Each other phase alone raises the condition
      @(posedge sys_clk);
      phb <= 12'h079;
      settle();
      chk({28'h0, zone_trip}, 32'h0000_0001);
      @(posedge sys_clk);
      phb <= 12'h000;
      phc <= 12'h079;
      settle();
      chk({28'h0, zone_trip}, 32'h0000_0001);
      @(posedge sys_clk);
      phc <= 12'h000;
      ph <= 12'h079;
      settle();
      chk({28'h0, zone_trip}, 32'h0000_0001);
      rd_chk(arcz_pkg::OFF_SENS, 32'h0000_0012);
      @(posedge sys_clk);
      ph <= 12'h000;
      // Residual source selection
      wr_reg(arcz_pkg::OFF_RES_PU, 32'h0000_1078);
      wr_reg(arcz_pkg::OFF_ZONE0, 32'h0000_000D);
      r2 <= 12'h200;
      settle();
      chk({28'h0, zone_trip}, 32'h0000_0000);
      @(posedge sys_clk);
      r1 <= 12'h200;
      settle();
      chk({28'h0, zone_trip}, 32'h0000_0001);
      @(posedge sys_clk);
      r1 <= 12'h000;
      wr_reg(arcz_pkg::OFF_RES_PU, 32'h0000_2078);
      settle();
      chk({28'h0, zone_trip}, 32'h0000_0001);
      @(posedge sys_clk);
      r2 <= 12'h000;
      sample_valid <= 1'b0;
      $display("test current done");
      // Out-of-range pick-up write is ignored
      wr_reg(arcz_pkg::OFF_PH_PU, 32'h0000_0004);
      rd_chk(arcz_pkg::OFF_PH_PU, 32'h0000_0078);
      // Modes: blocked, test, off
      wr_reg(arcz_pkg::OFF_ZONE0, 32'h0000_0009);
      wr_reg(arcz_pkg::OFF_CTRL, 32'h0000_0001);
      settle();
      chk({24'h0, zone_blocked, zone_trip}, 32'h0000_0010);
      wr_reg(arcz_pkg::OFF_CTRL, 32'h0000_0002);
      settle();
      chk({28'h0, zone_trip}, 32'h0000_0000);
      wr_reg(arcz_pkg::OFF_CTRL, 32'h0000_0003);
      settle();
      chk({24'h0, zone_blocked, zone_trip}, 32'h0000_0010);
      wr_reg(arcz_pkg::OFF_CTRL, 32'h0000_0004);
      settle();
      chk({24'h0, zone_blocked, zone_trip}, 32'h0000_0000);
      rd_chk(arcz_pkg::OFF_BEHAV, 32'h0000_0004);
      $display("test modes done");
      // Sensor status word
      @(posedge sys_clk);
      light <= 4'h5;
      pressure <= 4'hA;
      option_card_input <= 1'b1;
      sensor_fault <= 4'h3;
      io_fault <= 1'b1;
      settle();
      rd_reg(arcz_pkg::OFF_SENS, d);
      chk(d, {14'h0, 1'b1, 4'h3, 1'b1, 4'hA, 4'h5, 4'h0});
      $display("test status done");
      // Reset in mid-run brings flags and settings back
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      #1;
      chk({24'h0, zone_blocked, zone_trip}, 32'h0000_0000);
      rd_chk(arcz_pkg::OFF_CTRL, 32'h0000_0000);
      rd_chk(arcz_pkg::OFF_ZONE0, 32'h0000_0000);
      $display("test reset again done");
      finish_test();
   end
endmodule
